// ### core/cfb_channel_ctl.sv
// Channel filter stage control: registers, shadows, self-test, output path
`timescale 1ns/1ps
module cfb_channel_ctl #(
	parameter int RAM_CYC = cfb_pkg::RAM_BIST_CYC
) (
	input wire logic clk, // Sample clock, 20 MHz
	input wire logic arst_n, // Async reset, low
	input wire logic regWr, // Microport write strobe
	input wire logic regRd, // Microport read strobe
	input wire logic [cfb_pkg::AW-1:0] regAddr, // Channel address
	input wire logic [cfb_pkg::DW-1:0] regWrData, // Write data
	output logic [cfb_pkg::DW-1:0] regRdData, // Read data, one cycle later
	output logic coefWr, // Coefficient memory write pulse
	output logic [7:0] coefAddr, // Coefficient memory address
	output logic [cfb_pkg::DW-1:0] coefData, // Coefficient data
	input wire logic levelInd, // Level indicator active
	output logic expInvert, // Invert input exponent
	output logic expStep12dB, // Exponent step weight
	output logic [4:0] resScale, // Active resampler scale
	output logic [7:0] cic5DecM1, // Fifth-order decimation minus one
	output logic [4:0] cic5Scale, // Fifth-order gain scale
	output logic [7:0] filtDecM1, // Filter decimation minus one
	output logic [7:0] filtPhase, // Active decimation phase
	output logic [7:0] filtTapsM1, // Taps minus one
	output logic [7:0] coefPtr, // Active coefficient pointer
	input wire logic filterStart, // Filter computation starts
	input wire logic cicValid, // Own fifth-order sample
	input wire logic [cfb_pkg::SW-1:0] cicI, // Own I
	input wire logic [cfb_pkg::SW-1:0] cicQ, // Own Q
	input wire logic othValid, // Other channel sample
	input wire logic [cfb_pkg::SW-1:0] othI, // Other I
	input wire logic [cfb_pkg::SW-1:0] othQ, // Other Q
	output logic filtInValid, // Filter input sample
	output logic [cfb_pkg::SW-1:0] filtInI, // Filter input I
	output logic [cfb_pkg::SW-1:0] filtInQ, // Filter input Q
	input wire logic filtOutValid, // Filter output sample
	input wire logic [cfb_pkg::SW-1:0] filtOutI, // Filter output I
	input wire logic [cfb_pkg::SW-1:0] filtOutQ, // Filter output Q
	output logic srcReady, // Output path can take a sample
	output logic outValid, // Formatted word pair
	output logic [cfb_pkg::OW-1:0] outI, // Formatted I
	output logic [cfb_pkg::OW-1:0] outQ, // Formatted Q
	input wire logic outReady, // Receiver takes pair
	output logic ramBistRun, // Memory self-test running
	input wire logic cmemErr, // Coefficient memory miscompare
	input wire logic dmemErr // Data memory miscompare
);
	import cfb_pkg::*;

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	typedef struct packed {
		logic [11:0] scl;
		logic [7:0] c5Dec;
		logic [4:0] c5Scl;
		logic [7:0] fDec;
		logic [7:0] fPh;
		logic [7:0] taps;
		logic [7:0] coefOff;
		logic [10:0] ctl;
		logic [9:0] oCtl;
		logic [OW-1:0] sigI;
		logic [OW-1:0] sigQ;
		logic [OW-1:0] mapI;
		logic [OW-1:0] mapQ;
		logic [19:0] bCnt;
		cfb_rb_t rb;
		logic [10:0] rCnt;
		logic [2:0] rRes;
		logic cErr;
		logic dErr;
		logic [DW-1:0] rd;
		logic [7:0] phAct;
		logic [7:0] ptr;
		logic [4:0] resScl;
		logic cWr;
		logic [7:0] cAddr;
		logic [DW-1:0] cData;
		logic fVld;
		logic [SW-1:0] fI;
		logic [SW-1:0] fQ;
	} cfb_main_st_t;
	cfb_main_st_t s_r, s_nxt;

	// ---------------------------------------------
	// Output path
	// ---------------------------------------------
	logic bypass, mapOn, srcVld, push, bufRdy;
	logic [SW-1:0] srcI, srcQ;
	logic [OW-1:0] wI, wQ;
	assign bypass = s_r.ctl[CT_BYPASS];
	assign mapOn = s_r.oCtl[OC_MAP];
	assign srcVld = bypass ? cicValid : filtOutValid;
	assign srcI = bypass ? cicI : filtOutI;
	assign srcQ = bypass ? cicQ : filtOutQ;
	assign push = srcVld & bufRdy;
	cfb_format u_fmt (
		.dI(srcI),
		.dQ(srcQ),
		.fmt(s_r.ctl[CT_FMT_LSB+1:CT_FMT_LSB]),
		.common(s_r.ctl[CT_COMMON]),
		.force_(s_r.ctl[CT_FORCE]),
		.scale(s_r.ctl[CT_SCALE_LSB+3:CT_SCALE_LSB]),
		.wide(s_r.oCtl[OC_WIDE]),
		.bypass(bypass),
		.wI(wI),
		.wQ(wQ)
	);
	// Stall reaches the source through srcReady, so no word is dropped
	cfb_skid #(.W(2 * OW)) u_buf (
		.clk(clk),
		.arst_n(arst_n),
		.inValid(srcVld),
		.inData({wI, wQ}),
		.inReady(bufRdy),
		.outValid(outValid),
		.outData({outI, outQ}),
		.outReady(outReady)
	);

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	function automatic logic [OW-1:0] sigStep(input logic [OW-1:0] sig, input logic [OW-1:0] w);
		return {sig[OW-2:0], ^(sig & SIG_POLY)} ^ w;
	endfunction
	always_comb begin
		s_nxt = s_r;
		s_nxt.cWr = 1'b0;
		s_nxt.resScl = levelInd ? s_r.scl[SC_HIGH_LSB+4:SC_HIGH_LSB] : s_r.scl[SC_LOW_LSB+4:SC_LOW_LSB];
		// ---------------------------------------------
		// Shadows and input select
		// ---------------------------------------------
		// Running filter keeps its pointer until the next start
		if (filterStart) begin
			s_nxt.phAct = s_r.fPh;
			s_nxt.ptr = s_r.coefOff;
		end
		if (s_r.ctl[CT_INSEL]) begin
			s_nxt.fVld = othValid;
			s_nxt.fI = othI;
			s_nxt.fQ = othQ;
		end else begin
			s_nxt.fVld = cicValid;
			s_nxt.fI = cicI;
			s_nxt.fQ = cicQ;
		end
		// Signature runs only in signature mode, one step per accepted pair
		if (push && mapOn) begin
			s_nxt.mapI = wI;
			s_nxt.mapQ = wQ;
		end else if (push && s_r.bCnt != 20'h00000) begin
			s_nxt.sigI = sigStep(s_r.sigI, wI);
			s_nxt.sigQ = sigStep(s_r.sigQ, wQ);
			s_nxt.bCnt = s_r.bCnt - 20'h00001;
		end

		// ---------------------------------------------
		// Memory self-test
		// ---------------------------------------------
		unique case (s_r.rb)
			CFB_RB_IDLE: begin
			end
			CFB_RB_RUN: begin
				s_nxt.cErr = s_r.cErr | cmemErr;
				s_nxt.dErr = s_r.dErr | dmemErr;
				s_nxt.rCnt = s_r.rCnt - 11'h001;
				if (s_r.rCnt == 11'h000) begin
					s_nxt.rb = CFB_RB_IDLE;
					s_nxt.rRes[RB_EN] = 1'b0;
					s_nxt.rRes[RB_CFAIL] = s_r.cErr | cmemErr;
					s_nxt.rRes[RB_DFAIL] = s_r.dErr | dmemErr;
				end
			end
		endcase

		// ---------------------------------------------
		// Register writes
		// ---------------------------------------------
		if (regWr) begin
			if (regAddr <= ADR_COEF_LAST) begin
				s_nxt.cWr = 1'b1;
				s_nxt.cAddr = {s_r.ctl[CT_BANK], regAddr[6:0]};
				s_nxt.cData = regWrData;
			end
			case (regAddr)
				ADR_RES_SCALE: s_nxt.scl = regWrData[11:0];
				ADR_C5_DEC: s_nxt.c5Dec = regWrData[7:0];
				ADR_C5_SCALE: s_nxt.c5Scl = regWrData[4:0];
				ADR_F_DEC: s_nxt.fDec = regWrData[7:0];
				ADR_F_PHASE: s_nxt.fPh = regWrData[7:0];
				ADR_F_TAPS: s_nxt.taps = regWrData[7:0];
				ADR_COEF_OFF: s_nxt.coefOff = regWrData[7:0];
				ADR_F_CTL: s_nxt.ctl = regWrData[10:0];
				ADR_SIG_I: s_nxt.sigI = regWrData[OW-1:0];
				ADR_SIG_Q: s_nxt.sigQ = regWrData[OW-1:0];
				ADR_BIST_CNT: s_nxt.bCnt = regWrData[19:0];
				ADR_OUT_CTL: s_nxt.oCtl = regWrData[9:0] & OUT_CTL_MASK;
				ADR_RAM_BIST: begin
					if (regWrData[RB_EN] && s_r.rb == CFB_RB_IDLE) begin
						s_nxt.rb = CFB_RB_RUN;
						s_nxt.rCnt = 11'(RAM_CYC - 1);
						s_nxt.rRes = 3'b001;
						s_nxt.cErr = 1'b0;
						s_nxt.dErr = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// ---------------------------------------------
		// Register reads
		// ---------------------------------------------
		// Read data stands one cycle, zero otherwise
		s_nxt.rd = RST_ZERO;
		if (regRd) begin
			case (regAddr)
				ADR_RES_SCALE: s_nxt.rd = {8'h00, s_r.scl};
				ADR_C5_DEC: s_nxt.rd = {12'h000, s_r.c5Dec};
				ADR_C5_SCALE: s_nxt.rd = {15'h0000, s_r.c5Scl};
				ADR_F_DEC: s_nxt.rd = {12'h000, s_r.fDec};
				ADR_F_PHASE: s_nxt.rd = {12'h000, s_r.fPh};
				ADR_F_TAPS: s_nxt.rd = {12'h000, s_r.taps};
				ADR_COEF_OFF: s_nxt.rd = {12'h000, s_r.coefOff};
				ADR_F_CTL: s_nxt.rd = {9'h000, s_r.ctl};
				ADR_SIG_I: s_nxt.rd = {4'h0, mapOn ? s_r.mapI : s_r.sigI};
				ADR_SIG_Q: s_nxt.rd = {4'h0, mapOn ? s_r.mapQ : s_r.sigQ};
				ADR_BIST_CNT: s_nxt.rd = s_r.bCnt;
				ADR_RAM_BIST: s_nxt.rd = {17'h00000, s_r.rRes};
				ADR_OUT_CTL: s_nxt.rd = {10'h000, s_r.oCtl};
				default: s_nxt.rd = RST_ZERO;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign regRdData = s_r.rd;
	assign coefWr = s_r.cWr;
	assign coefAddr = s_r.cAddr;
	assign coefData = s_r.cData;
	assign expInvert = s_r.scl[SC_EXP_INV];
	assign expStep12dB = s_r.scl[SC_EXP_WT];
	assign resScale = s_r.resScl;
	assign cic5DecM1 = s_r.c5Dec;
	assign cic5Scale = s_r.c5Scl;
	assign filtDecM1 = s_r.fDec;
	assign filtPhase = s_r.phAct;
	assign filtTapsM1 = s_r.taps;
	assign coefPtr = s_r.ptr;
	assign filtInValid = s_r.fVld;
	assign filtInI = s_r.fI;
	assign filtInQ = s_r.fQ;
	assign srcReady = bufRdy;
	assign ramBistRun = s_r.rb == CFB_RB_RUN;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	a_phase_load: assert property (@(posedge clk) disable iff (!arst_n)
		filterStart |=> filtPhase == $past(s_r.fPh)) else $error("phase not loaded at filter start");
	a_ptr_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!filterStart |=> $stable(coefPtr)) else $error("coefficient pointer moved without start");
	a_scale_pick: assert property (@(posedge clk) disable iff (!arst_n)
		levelInd && !regWr |=> resScale == s_r.scl[4:0]) else $error("wrong scale for active indicator");
	a_ram_done: assert property (@(posedge clk) disable iff (!arst_n)
		s_r.rb == CFB_RB_RUN && s_r.rCnt == 11'h000 |=> !ramBistRun && s_r.rRes[RB_EN] == 1'b0)
		else $error("memory test did not finish");
	a_ram_len: assert property (@(posedge clk) disable iff (!arst_n)
		s_r.rb == CFB_RB_RUN |-> s_r.rCnt < 11'(RAM_CYC)) else $error("memory test counter out of range");
	a_bist_load: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr == ADR_BIST_CNT |=> s_r.bCnt == $past(regWrData)) else $error("count not loaded");
	a_bist_stop: assert property (@(posedge clk) disable iff (!arst_n)
		s_r.bCnt == 20'h00000 && !regWr |=> $stable(s_r.sigI) && $stable(s_r.sigQ))
		else $error("signature moved after count ran out");
	a_map_read: assert property (@(posedge clk) disable iff (!arst_n)
		regRd && regAddr == ADR_SIG_I && mapOn |=> regRdData == {4'h0, $past(s_r.mapI)})
		else $error("mapped word not returned");
	a_coef_bank: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr <= ADR_COEF_LAST |=> coefWr && coefAddr[7] == $past(s_r.ctl[CT_BANK]))
		else $error("coefficient bank bit wrong");

	a_c5_load: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr == ADR_C5_DEC |=> cic5DecM1 == $past(regWrData[7:0]))
		else $error("fifth-order decimation not loaded");
	a_dec_load: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr == ADR_F_DEC |=> filtDecM1 == $past(regWrData[7:0]))
		else $error("filter decimation not loaded");
	a_taps_load: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr == ADR_F_TAPS |=> filtTapsM1 == $past(regWrData[7:0]))
		else $error("tap count not loaded");
	a_scale_bits: assert property (@(posedge clk) disable iff (!arst_n)
		regWr && regAddr == ADR_RES_SCALE |=> expInvert == $past(regWrData[SC_EXP_INV])
		&& expStep12dB == $past(regWrData[SC_EXP_WT])) else $error("exponent control bits not loaded");
	a_scale_low: assert property (@(posedge clk) disable iff (!arst_n)
		!levelInd && !regWr |=> resScale == s_r.scl[SC_LOW_LSB+4:SC_LOW_LSB])
		else $error("wrong scale for quiet indicator");

	a_ptr_load: assert property (@(posedge clk) disable iff (!arst_n)
		filterStart |=> coefPtr == $past(s_r.coefOff))
		else $error("coefficient pointer not loaded at start");
	a_insel_own: assert property (@(posedge clk) disable iff (!arst_n)
		!s_r.ctl[CT_INSEL] && cicValid |=> filtInValid && filtInI == $past(cicI) && filtInQ == $past(cicQ))
		else $error("own sample not routed to filter");
	a_insel_other: assert property (@(posedge clk) disable iff (!arst_n)
		s_r.ctl[CT_INSEL] && othValid |=> filtInValid && filtInI == $past(othI) && filtInQ == $past(othQ))
		else $error("other channel sample not routed to filter");
	a_bypass_map: assert property (@(posedge clk) disable iff (!arst_n)
		bypass && mapOn && cicValid && bufRdy |=> s_r.mapI == $past(cicI[SW-1:SW-16]))
		else $error("bypassed sample not mapped");

	a_coef_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		!(regWr && regAddr <= ADR_COEF_LAST) |=> !coefWr)
		else $error("coefficient write without host write");
	a_sig_count: assert property (@(posedge clk) disable iff (!arst_n)
		push && !mapOn && s_r.bCnt != 20'h00000 && !regWr |=> s_r.bCnt == $past(s_r.bCnt) - 20'h00001)
		else $error("output count not stepped");
	a_ram_flag: assert property (@(posedge clk) disable iff (!arst_n)
		ramBistRun |-> s_r.rRes[RB_EN])
		else $error("enable bit low while memory test runs");
	a_rsvd_read: assert property (@(posedge clk) disable iff (!arst_n)
		regRd && (regAddr == ADR_RSVD_A || regAddr == ADR_RSVD_B) |=> regRdData == RST_ZERO)
		else $error("reserved register read not zero");
endmodule

// ### core/cfb_format.sv
// Output formatter: fixed point, 12+4 and 8+4 floating point
`timescale 1ns/1ps
module cfb_format (
	input wire logic [cfb_pkg::SW-1:0] dI, // I sample
	input wire logic [cfb_pkg::SW-1:0] dQ, // Q sample
	input wire logic [1:0] fmt, // Output format
	input wire logic common, // Shared exponent
	input wire logic force_, // Force output scale
	input wire logic [3:0] scale, // Output scale factor
	input wire logic wide, // 16-bit fixed words
	input wire logic bypass, // Pass raw top bits
	output logic [cfb_pkg::OW-1:0] wI, // Formatted I
	output logic [cfb_pkg::OW-1:0] wQ // Formatted Q
);
	import cfb_pkg::*;
	function automatic logic [3:0] redund(input logic [SW-1:0] x);
		logic [3:0] c;
		logic stop;
		c = 4'd0;
		stop = 1'b0;
		for (int b = SW - 2; b >= SW - 16; b--) begin
			if (!stop && x[b] == x[SW-1]) begin
				c = c + 4'd1;
			end else begin
				stop = 1'b1;
			end
		end
		return c;
	endfunction
	logic [3:0] rI, rQ, rMin;
	logic [SW-1:0] lane [2];
	logic [OW-1:0] word [2];
	assign rI = redund(dI);
	assign rQ = redund(dQ);
	assign rMin = (rI < rQ) ? rI : rQ;
	assign lane[0] = dI;
	assign lane[1] = dQ;
	assign wI = word[0];
	assign wQ = word[1];
	for (genvar k = 0; k < 2; k++) begin : g_lane
		logic [3:0] e;
		logic [SW+15:0] sh;
		logic [SW-1:0] m;
		always_comb begin
			if (fmt == 2'b00 || force_) begin
				e = scale;
			end else if (common) begin
				e = rMin;
			end else begin
				e = (k == 0) ? rI : rQ;
			end
			sh = {{16{lane[k][SW-1]}}, lane[k]} << e;
			// Clip instead of wrapping when the scale is too large
			if (sh[SW+15:SW-1] != {(17){sh[SW+15]}}) begin
				m = {sh[SW+15], {(SW-1){~sh[SW+15]}}};
			end else begin
				m = sh[SW-1:0];
			end
			if (bypass) begin
				word[k] = lane[k][SW-1:SW-16];
			end else if (fmt[1]) begin
				word[k] = {m[SW-1:SW-12], e};
			end else if (fmt[0]) begin
				word[k] = {m[SW-1:SW-8], e, 4'h0};
			end else if (wide) begin
				word[k] = m[SW-1:SW-16];
			end else begin
				word[k] = {m[SW-1:SW-12], 4'h0};
			end
		end
	end
endmodule

// ### core/cfb_pkg.sv
// Shared constants and types for the channel filter stage control block
package cfb_pkg;
	localparam int AW = 8;
	localparam int DW = 20;
	localparam int SW = 24;
	localparam int OW = 16;
	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [7:0] ADR_COEF_LAST = 8'h7f;
	localparam logic [7:0] ADR_RES_SCALE = 8'h92;
	localparam logic [7:0] ADR_RSVD_A = 8'h93;
	localparam logic [7:0] ADR_C5_DEC = 8'h94;
	localparam logic [7:0] ADR_C5_SCALE = 8'h95;
	localparam logic [7:0] ADR_RSVD_B = 8'h96;
	localparam logic [7:0] ADR_F_DEC = 8'ha0;
	localparam logic [7:0] ADR_F_PHASE = 8'ha1;
	localparam logic [7:0] ADR_F_TAPS = 8'ha2;
	localparam logic [7:0] ADR_COEF_OFF = 8'ha3;
	localparam logic [7:0] ADR_F_CTL = 8'ha4;
	localparam logic [7:0] ADR_SIG_I = 8'ha5;
	localparam logic [7:0] ADR_SIG_Q = 8'ha6;
	localparam logic [7:0] ADR_BIST_CNT = 8'ha7;
	localparam logic [7:0] ADR_RAM_BIST = 8'ha8;
	localparam logic [7:0] ADR_OUT_CTL = 8'ha9;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int SC_EXP_INV = 11;
	localparam int SC_EXP_WT = 10;
	localparam int SC_HIGH_LSB = 0;
	localparam int SC_LOW_LSB = 5;
	localparam int CT_BYPASS = 10;
	localparam int CT_INSEL = 9;
	localparam int CT_BANK = 8;
	localparam int CT_COMMON = 7;
	localparam int CT_FORCE = 6;
	localparam int CT_FMT_LSB = 4;
	localparam int CT_SCALE_LSB = 0;
	localparam int OC_MAP = 9;
	localparam int OC_WIDE = 5;
	localparam int RB_EN = 0;
	localparam int RB_CFAIL = 1;
	localparam int RB_DFAIL = 2;
	// ---------------------------------------------
	// Reset values, masks, timing
	// ---------------------------------------------
	localparam logic [DW-1:0] RST_ZERO = 20'h00000;
	localparam logic [9:0] OUT_CTL_MASK = 10'h220;
	localparam logic [OW-1:0] SIG_POLY = 16'hb400;
	localparam int RAM_BIST_CYC = 1600;
	typedef enum logic {CFB_RB_IDLE, CFB_RB_RUN} cfb_rb_t;
endpackage

// ### core/cfb_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module cfb_skid #(
	parameter int W = 32
) (
	input wire logic clk, // Sample clock
	input wire logic arst_n, // Async reset, low
	input wire logic inValid, // Word offered
	input wire logic [W-1:0] inData, // Word
	output logic inReady, // Room for a word
	output logic outValid, // Word held
	output logic [W-1:0] outData, // Head word
	input wire logic outReady // Receiver takes head
);
	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0] cnt;
		logic vld;
		logic rdy;
	} cfb_skid_st_t;
	cfb_skid_st_t s_r, s_nxt;
	logic push, pop;
	logic [1:0] idx;
	assign push = inValid & s_r.rdy;
	assign pop = s_r.vld & outReady;
	always_comb begin
		s_nxt = s_r;
		idx = s_r.cnt - {1'b0, pop};
		if (pop) begin
			s_nxt.d0 = s_r.d1;
		end
		if (push) begin
			if (idx == 2'd0) begin
				s_nxt.d0 = inData;
			end else begin
				s_nxt.d1 = inData;
			end
		end
		s_nxt.cnt = idx + {1'b0, push};
		s_nxt.vld = s_nxt.cnt != 2'd0;
		// Ready is registered so the source sees a clean stall
		s_nxt.rdy = s_nxt.cnt != 2'd2;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{d0: '0, d1: '0, cnt: 2'd0, vld: 1'b0, rdy: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign inReady = s_r.rdy;
	assign outValid = s_r.vld;
	assign outData = s_r.d0;
endmodule

// ### sim/cfb_host_model.sv
// Host processor model driving the channel microport
`timescale 1ns/1ps
module cfb_host_model #(
	parameter int WAIT_CYC = 1600
) (
	input wire logic clk, // Sample clock
	output logic regWr, // Write strobe
	output logic regRd, // Read strobe
	output logic [cfb_pkg::AW-1:0] regAddr, // Channel address
	output logic [cfb_pkg::DW-1:0] regWrData, // Write data
	input wire logic [cfb_pkg::DW-1:0] regRdData // Read data
);
	import cfb_pkg::*;
	initial begin
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 20'h00000;
	end
	task automatic wr(input logic [7:0] a, input logic [19:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= (a == ADR_RSVD_A || a == ADR_RSVD_B) ? 20'h00000 : d;
		@(posedge clk);
		regWr <= 1'b0;
		// Released data bus never shows the last word, except after a reserved write of 20'hfffff
		regWrData <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [19:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask
	task automatic ram_test(output logic [19:0] res);
		wr(ADR_RAM_BIST, 20'h00001);
		repeat (WAIT_CYC) @(posedge clk);
		rd(ADR_RAM_BIST, res);
	endtask
endmodule

// ### sim/test_cfb_channel_ctl.sv
// Self-checking bench for the channel filter stage control block
`timescale 1ns/1ps
module test_cfb_channel_ctl;
	import cfb_pkg::*;
	localparam int RAMC = 8;
	localparam int LIMIT = 4000;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic regWr, regRd, coefWr, levelInd, expInvert, expStep12dB, filterStart, cicValid, othValid;
	logic filtInValid, filtOutValid, srcReady, outValid, outReady, ramBistRun, cmemErr, dmemErr;
	logic [7:0] regAddr, coefAddr, cic5DecM1, filtDecM1, filtPhase, filtTapsM1, coefPtr;
	logic [19:0] regWrData, regRdData, coefData;
	logic [4:0] resScale, cic5Scale;
	logic [23:0] cicI, cicQ, othI, othQ, filtInI, filtInQ, filtOutI, filtOutQ;
	logic [15:0] outI, outQ;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	cfb_channel_ctl #(.RAM_CYC(RAMC)) i_dut (.clk(clk), .arst_n(arst_n), .regWr(regWr), .regRd(regRd),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .coefWr(coefWr),
		.coefAddr(coefAddr), .coefData(coefData), .levelInd(levelInd), .expInvert(expInvert),
		.expStep12dB(expStep12dB), .resScale(resScale), .cic5DecM1(cic5DecM1), .cic5Scale(cic5Scale),
		.filtDecM1(filtDecM1), .filtPhase(filtPhase), .filtTapsM1(filtTapsM1), .coefPtr(coefPtr),
		.filterStart(filterStart), .cicValid(cicValid), .cicI(cicI), .cicQ(cicQ), .othValid(othValid),
		.othI(othI), .othQ(othQ), .filtInValid(filtInValid), .filtInI(filtInI), .filtInQ(filtInQ),
		.filtOutValid(filtOutValid), .filtOutI(filtOutI), .filtOutQ(filtOutQ), .srcReady(srcReady),
		.outValid(outValid), .outI(outI), .outQ(outQ), .outReady(outReady), .ramBistRun(ramBistRun),
		.cmemErr(cmemErr), .dmemErr(dmemErr));
	cfb_host_model #(.WAIT_CYC(RAMC + 2)) i_host (.clk(clk), .regWr(regWr), .regRd(regRd),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			give_verdict();
		end
	end
	function automatic logic [15:0] sstep(input logic [15:0] s, input logic [15:0] w);
		return {s[14:0], ^(s & SIG_POLY)} ^ w;
	endfunction
	// Source holds its sample until the output path has room
	task automatic push(input logic byp, input logic [23:0] i, input logic [23:0] q);
		@(posedge clk);
		cicValid <= byp;
		filtOutValid <= !byp;
		cicI <= i;
		cicQ <= q;
		filtOutI <= i;
		filtOutQ <= q;
		do @(posedge clk); while (!srcReady);
		cicValid <= 1'b0;
		filtOutValid <= 1'b0;
		#1;
	endtask
	task automatic t_regs();
		logic [19:0] v;
		i_host.wr(ADR_RES_SCALE, 20'h00c3e);
		chk(expInvert, 1);
		chk(expStep12dB, 1);
		@(posedge clk);
		#1;
		chk(resScale, 5'h01);
		@(posedge clk);
		levelInd <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(resScale, 5'h1e);
		i_host.wr(ADR_C5_DEC, 20'h0001f);
		chk(cic5DecM1, 8'h1f);
		i_host.wr(ADR_C5_SCALE, 20'hfff35);
		chk(cic5Scale, 5'h15);
		i_host.rd(ADR_C5_SCALE, v);
		chk(v, 20'h00015);
		i_host.wr(ADR_F_DEC, 20'h000ff);
		chk(filtDecM1, 8'hff);
		i_host.wr(ADR_F_TAPS, 20'h0003f);
		chk(filtTapsM1, 8'h3f);
		i_host.wr(ADR_RSVD_A, 20'hfffff);
		i_host.rd(ADR_RSVD_A, v);
		chk(v, 20'h00000);
		i_host.rd(8'h97, v);
		chk(v, 20'h00000);
	endtask
	task automatic t_shadow();
		i_host.wr(ADR_F_PHASE, 20'h00003);
		i_host.wr(ADR_COEF_OFF, 20'h00040);
		chk(filtPhase, 8'h00);
		chk(coefPtr, 8'h00);
		@(posedge clk);
		filterStart <= 1'b1;
		@(posedge clk);
		filterStart <= 1'b0;
		#1;
		chk(filtPhase, 8'h03);
		chk(coefPtr, 8'h40);
		i_host.wr(ADR_F_PHASE, 20'h00005);
		chk(filtPhase, 8'h03);
	endtask
	task automatic t_coef();
		i_host.wr(ADR_F_CTL, 20'h00100);
		i_host.wr(8'h05, 20'habcde);
		chk(coefWr, 1);
		chk(coefAddr, 8'h85);
		chk(coefData, 20'habcde);
		@(posedge clk);
		#1;
		chk(coefWr, 0);
	endtask
	task automatic t_insel();
		for (int s = 0; s < 2; s++) begin
			i_host.wr(ADR_F_CTL, s ? 20'h00200 : 20'h00000);
			@(posedge clk);
			cicValid <= 1'b1;
			othValid <= 1'b1;
			cicI <= 24'h111111;
			othI <= 24'h222222;
			cicQ <= 24'h333333;
			othQ <= 24'h444444;
			@(posedge clk);
			cicValid <= 1'b0;
			othValid <= 1'b0;
			#1;
			chk(filtInValid, 1);
			chk(filtInI, s ? 24'h222222 : 24'h111111);
			chk(filtInQ, s ? 24'h444444 : 24'h333333);
		end
	endtask
	task automatic t_format();
		logic [19:0] v;
		i_host.wr(ADR_OUT_CTL, 20'h00220);
		i_host.wr(ADR_F_CTL, 20'h00002);
		push(1'b0, 24'h001234, 24'hc00000);
		chk(outI, 16'h0048);
		chk(outQ, 16'h8000);
		push(1'b0, 24'h400000, 24'h000000);
		chk(outI, 16'h7fff);
		i_host.rd(ADR_SIG_I, v);
		chk(v, 20'h07fff);
		i_host.wr(ADR_OUT_CTL, 20'h00200);
		push(1'b0, 24'h001234, 24'h000000);
		chk(outI, 16'h0040);
		i_host.wr(ADR_F_CTL, 20'h00020);
		push(1'b0, 24'h001000, 24'h400000);
		chk(outI[3:0], 4'ha);
		i_host.wr(ADR_F_CTL, 20'h000a0);
		push(1'b0, 24'h001000, 24'h400000);
		chk(outI[3:0], 4'h0);
		i_host.wr(ADR_F_CTL, 20'h00010);
		push(1'b0, 24'h001000, 24'h400000);
		chk(outI[7:0], 8'ha0);
		i_host.wr(ADR_F_CTL, 20'h00062);
		push(1'b0, 24'h400000, 24'h001234);
		chk(outI, 16'h7ff2);
		chk(outQ, 16'h0042);
	endtask
	task automatic t_buffer();
		logic [19:0] v;
		i_host.wr(ADR_F_CTL, 20'h00400);
		@(posedge clk);
		outReady <= 1'b0;
		push(1'b1, 24'haaaa00, 24'h000000);
		push(1'b1, 24'h555500, 24'h000000);
		chk(srcReady, 0);
		chk(outI, 16'haaaa);
		@(posedge clk);
		outReady <= 1'b1;
		@(posedge clk);
		#1;
		chk(outI, 16'h5555);
		@(posedge clk);
		#1;
		chk(outValid, 0);
		i_host.rd(ADR_SIG_I, v);
		chk(v, 20'h05555);
	endtask
	task automatic t_sig();
		logic [19:0] v;
		i_host.wr(ADR_OUT_CTL, 20'h00000);
		i_host.wr(ADR_SIG_I, 20'h00000);
		i_host.wr(ADR_BIST_CNT, 20'h00002);
		i_host.rd(ADR_BIST_CNT, v);
		chk(v, 20'h00002);
		push(1'b1, 24'h800100, 24'h000000);
		i_host.rd(ADR_BIST_CNT, v);
		chk(v, 20'h00001);
		push(1'b1, 24'h123400, 24'h000000);
		push(1'b1, 24'hffff00, 24'h000000);
		i_host.rd(ADR_BIST_CNT, v);
		chk(v, 20'h00000);
		i_host.rd(ADR_SIG_I, v);
		chk(v, {4'h0, sstep(sstep(16'h0000, 16'h8001), 16'h1234)});
	endtask
	task automatic t_ram();
		logic [19:0] v;
		for (int k = 0; k < 2; k++) begin
			fork
				i_host.ram_test(v);
				begin
					repeat (3) @(posedge clk);
					cmemErr <= (k == 0);
					dmemErr <= (k == 1);
					@(posedge clk);
					cmemErr <= 1'b0;
					dmemErr <= 1'b0;
					#1;
					chk(ramBistRun, 1);
				end
			join
			chk(v, k ? 20'h00004 : 20'h00002);
		end
	endtask
	initial begin
		logic [19:0] v;
		{levelInd, filterStart, cicValid, othValid, filtOutValid, cmemErr, dmemErr} = 7'h00;
		{cicI, cicQ, othI, othQ, filtOutI, filtOutQ} = 144'h0;
		outReady = 1'b1;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk(srcReady, 1);
		chk(outValid, 0);
		i_host.rd(ADR_F_CTL, v);
		chk(v, 20'h00000);
		t_regs();
		t_shadow();
		t_coef();
		t_insel();
		t_format();
		t_buffer();
		t_sig();
		t_ram();
		give_verdict();
	end
endmodule
